// file: rtl/ppmr_pkg.sv
// Constants of the power management register bank.
// Assumes byte offsets on an 8-bit configuration address.
package ppmr_pkg;
  typedef enum logic [1:0] {
    PWR_D0    = 2'h0,
    PWR_D1    = 2'h1,
    PWR_D2    = 2'h2,
    PWR_D3HOT = 2'h3
  } ppmr_pstate_e;

  localparam logic [7:0]  OFS_CAP_ID      = 8'ha0;
  localparam logic [7:0]  OFS_CAPS        = 8'ha2;
  localparam logic [7:0]  OFS_CSR         = 8'ha4;
  localparam logic [7:0]  OFS_BRIDGE      = 8'ha6;
  localparam logic [7:0]  CAP_ID_VAL      = 8'h01;
  localparam logic [7:0]  NEXT_PTR_VAL    = 8'h00;
  localparam logic [7:0]  PM_DATA_VAL     = 8'h00;
  localparam logic [15:0] CSR_RESET       = 16'h0000;
  localparam logic [7:0]  BRIDGE_RESET    = 8'hc0;
  localparam int          BRIDGE_BPCC_BIT = 7;
  localparam int          BRIDGE_B2B3_BIT = 6;
  localparam int          CAP_D3COLD_BIT  = 15;
  localparam logic        CAP_D3COLD_RST  = 1'b1;
  localparam logic [5:0]  CAP_STATES_VAL  = 6'h3f;
  localparam logic        CAP_DSI_VAL     = 1'b0;
  localparam logic        CAP_AUX_VAL     = 1'b0;
  localparam logic        CAP_CLK_VAL     = 1'b0;
  localparam logic [2:0]  VER_REV11       = 3'h2;
  localparam logic [2:0]  VER_REV12       = 3'h3;
  localparam int          CSR_STATUS_BIT  = 15;
  localparam int          CSR_ENABLE_BIT  = 8;
  localparam logic [1:0]  DYN_SCALE_VAL   = 2'h0;
  localparam logic [3:0]  DYN_SELECT_VAL  = 4'h0;
endpackage

// file: rtl/ppmr_wake.sv
// Wake status and wake enable with their reset domains.
// Assumes wake_event is a one-cycle pulse from the function's logic.
`timescale 1ns/10ps
module ppmr_wake (
  input  wire logic sys_clk,       // Clock
  input  wire logic srst,          // Global reset
  input  wire logic bus_reset_in,  // Bus reset
  input  wire logic wake_event,    // Function would signal wake
  input  wire logic status_clr,    // Write of one to status
  input  wire logic enable_wr,     // Write to enable byte
  input  wire logic enable_wdata,  // New enable value
  output logic      wake_status,   // Sticky wake status
  output logic      wake_enable,   // Wake enable
  output logic      wake_out       // Wake asserted by this function
);
  logic wake_status_ff;
  logic wake_enable_ff;
  logic wake_out_ff;
  logic nxt_wake_status;
  logic nxt_wake_enable;

  // Event wins over a clear in the same cycle
  always_comb begin
    nxt_wake_status = wake_status_ff;
    if (status_clr) begin
      nxt_wake_status = 1'b0;                          // R8
    end
    if (bus_reset_in && !wake_enable_ff) begin
      nxt_wake_status = 1'b0;                          // R14
    end
    if (wake_event) begin
      nxt_wake_status = 1'b1;                          // R7
    end
    nxt_wake_enable = enable_wr ? enable_wdata : wake_enable_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_status_ff <= 1'b0;
    end else begin
      wake_status_ff <= nxt_wake_status;
    end
  end

  // Bus reset deliberately not applied here
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_enable_ff <= 1'b0;                          // R11
    end else begin
      wake_enable_ff <= nxt_wake_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wake_out_ff <= 1'b0;
    end else begin
      wake_out_ff <= nxt_wake_status && nxt_wake_enable; // R10
    end
  end

  assign wake_status = wake_status_ff;
  assign wake_enable = wake_enable_ff;
  assign wake_out    = wake_out_ff;
endmodule

// file: rtl/ppmr_secbus.sv
// Secondary bus clock and power control from the power state.
// Assumes the state input is the live power-state register.
`timescale 1ns/10ps
module ppmr_secbus
  import ppmr_pkg::*;
(
  input  wire logic         sys_clk,       // Clock
  input  wire logic         srst,          // Global reset
  input  wire logic [1:0]   power_state,   // Current power state
  input  wire logic [7:0]   bridge_ext,    // Bridge extension contents
  output logic              sec_clk_stop,  // Stop secondary clock
  output logic              sec_power_off  // Remove secondary power
);
  logic sec_clk_stop_ff;
  logic sec_power_off_ff;
  logic in_d3hot;
  logic bpcc;

  assign in_d3hot = (power_state == PWR_D3HOT);
  assign bpcc     = bridge_ext[BRIDGE_BPCC_BIT];

  // Without bus control the state field never reaches the bus
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sec_clk_stop_ff  <= 1'b0;
      sec_power_off_ff <= 1'b0;
    end else begin
      sec_clk_stop_ff  <= bpcc && in_d3hot && bridge_ext[BRIDGE_B2B3_BIT];  // R16 R17
      sec_power_off_ff <= bpcc && in_d3hot && !bridge_ext[BRIDGE_B2B3_BIT]; // R16 R17
    end
  end

  assign sec_clk_stop  = sec_clk_stop_ff;
  assign sec_power_off = sec_power_off_ff;
endmodule

// file: rtl/ppmr_top.sv
// Power management configuration registers of a card bridge function.
// Assumes one configuration request per cycle at most, on sys_clk.
// How it works
// (R1) Device-specific init bit reads zero, read-only
// (R2) Aux power bit zero, zero without D3cold
// (R3) Clock-dependence bit read-only, zero without wake
// (R4) Version 010b or 011b by revision select
// (R5) Control/status untouched by D3hot-to-D0 reset
// (R6) D3hot-to-D0 pulses internal function reset
// (R7) Wake status sets on every wake event
// (R8) Writing one clears status and wake
// (R9) Data scale and select read zero
// (R10) Wake enable gates the wake output
// (R11) Wake enable cleared by global reset only
// (R12) Reserved bits read zero
// (R13) Power state readable, writable, four encodings
// (R14) Wake status survives bus reset if enabled
// (R15) Bus power/clock control bit reads one
// (R16) Disabled control leaves secondary bus alone
// (R17) D3HOT_SECONDARY_ACTION bit one: D3hot stops clock
// (R18) D3cold wake bit writable, defaults one
// (R19) Writes to read-only fields are ignored
`timescale 1ns/10ps
module ppmr_top
  import ppmr_pkg::*;
(
  input  wire logic        sys_clk,          // 250 MHz clock
  input  wire logic        srst,             // Global reset, active high
  input  wire logic        bus_reset_in,     // Bus reset, active high
  input  wire logic        cfg_req,          // Configuration request
  input  wire logic        cfg_we,           // High for write
  input  wire logic [7:0]  cfg_addr,         // Byte address
  input  wire logic [3:0]  cfg_be,           // Byte enables
  input  wire logic [31:0] cfg_wdata,        // Write data
  output logic [31:0]      cfg_rdata,        // Read data
  output logic             cfg_ack,          // Answer pulse
  input  wire logic        revision_select,  // Device control select bit
  input  wire logic        wake_event,       // Function would signal wake
  output logic             wake_out,         // Wake asserted
  output logic             func_reset,       // Internal reset pulse
  output logic [1:0]       power_state,      // Current power state
  output logic             sec_clk_stop,     // Secondary clock stopped
  output logic             sec_power_off     // Secondary power removed
);
  import ppmr_pkg::*;

  logic [1:0]  power_state_field_ff;
  logic        d3cold_wake_ff;
  logic        func_reset_ff;
  logic [31:0] cfg_rdata_ff;
  logic        cfg_ack_ff;
  logic [1:0]  nxt_power_state;
  logic        wr_cap_dw;
  logic        wr_csr_dw;
  logic        rd_req;
  logic        wake_status;
  logic        wake_enable;
  logic        aux_supply_flag;
  logic        wake_needs_clock;
  logic [2:0]  version;
  logic [15:0] caps_word;
  logic [15:0] csr_word;
  logic [7:0]  bridge_word;
  logic [31:0] rd_mux;
  logic        wake_any_state;

  assign wr_cap_dw = cfg_req && cfg_we && (cfg_addr[7:2] == OFS_CAP_ID[7:2]);
  assign wr_csr_dw = cfg_req && cfg_we && (cfg_addr[7:2] == OFS_CSR[7:2]);
  assign rd_req    = cfg_req && !cfg_we;

  // Capability field values
  assign wake_any_state   = d3cold_wake_ff || (|CAP_STATES_VAL[5:2]);
  assign aux_supply_flag  = CAP_AUX_VAL && d3cold_wake_ff;    // R2
  assign wake_needs_clock = CAP_CLK_VAL && wake_any_state;    // R3
  assign version          = revision_select ? VER_REV12 : VER_REV11; // R4

  assign caps_word = {d3cold_wake_ff,
                      CAP_STATES_VAL[5:2],
                      CAP_STATES_VAL[1:0],
                      3'h0,
                      CAP_DSI_VAL,                             // R1
                      aux_supply_flag,
                      wake_needs_clock,
                      version};

  assign csr_word = {wake_status,
                     DYN_SCALE_VAL,                            // R9
                     DYN_SELECT_VAL,                           // R9
                     wake_enable,
                     6'h00,                                    // R12
                     power_state_field_ff};                    // R13

  // Fixed content; bits 5..0 reserved and zero
  assign bridge_word = BRIDGE_RESET;                           // R15 R17 R12

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (cfg_addr[7:2])
      OFS_CAP_ID[7:2]: begin
        rd_mux = {caps_word, NEXT_PTR_VAL, CAP_ID_VAL};
      end
      OFS_CSR[7:2]: begin
        rd_mux = {PM_DATA_VAL, bridge_word, csr_word};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after every request, read or write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_ack_ff <= 1'b0;
    end else begin
      cfg_ack_ff <= cfg_req;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_rdata_ff <= 32'h0000_0000;
    end else if (rd_req) begin
      cfg_rdata_ff <= rd_mux;
    end
  end

  // Only byte lane 3 of the capability word is writable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      d3cold_wake_ff <= CAP_D3COLD_RST;                        // R18
    end else if (wr_cap_dw && cfg_be[3]) begin
      d3cold_wake_ff <= cfg_wdata[16 + CAP_D3COLD_BIT];        // R18 R19
    end
  end

  // Internal reset must not touch this register
  always_comb begin
    nxt_power_state = power_state_field_ff;
    if (wr_csr_dw && cfg_be[0]) begin
      nxt_power_state = cfg_wdata[1:0];                        // R13 R19
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || bus_reset_in) begin
      power_state_field_ff <= CSR_RESET[1:0];
    end else begin
      power_state_field_ff <= nxt_power_state;                 // R5
    end
  end

  // One-cycle reset for the rest of the function
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      func_reset_ff <= 1'b0;
    end else begin
      func_reset_ff <= (power_state_field_ff == PWR_D3HOT) &&
                       (nxt_power_state == PWR_D0) &&
                       !bus_reset_in;                          // R6
    end
  end

  ppmr_wake u_wake (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .bus_reset_in (bus_reset_in),
    .wake_event   (wake_event),
    .status_clr   (wr_csr_dw && cfg_be[1] && cfg_wdata[CSR_STATUS_BIT]), // R8
    .enable_wr    (wr_csr_dw && cfg_be[1]),
    .enable_wdata (cfg_wdata[CSR_ENABLE_BIT]),
    .wake_status  (wake_status),
    .wake_enable  (wake_enable),
    .wake_out     (wake_out)
  );

  ppmr_secbus u_secbus (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .power_state   (power_state_field_ff),
    .bridge_ext    (bridge_word),
    .sec_clk_stop  (sec_clk_stop),
    .sec_power_off (sec_power_off)
  );

  assign cfg_rdata   = cfg_rdata_ff;
  assign cfg_ack     = cfg_ack_ff;
  assign func_reset  = func_reset_ff;
  assign power_state = power_state_field_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_csr_read;
    rd_req && (cfg_addr[7:2] == OFS_CSR[7:2]);
  endsequence

  sequence s_cap_read;
    rd_req && (cfg_addr[7:2] == OFS_CAP_ID[7:2]);
  endsequence

  sequence s_leave_d3hot;
    (power_state_field_ff == PWR_D3HOT) && wr_csr_dw && cfg_be[0] &&
    (cfg_wdata[1:0] == 2'h0) && !bus_reset_in;
  endsequence

  a_cap_fixed_bits: assert property (s_cap_read |=> // R1
    cfg_rdata[21] == 1'b0 && cfg_rdata[24:22] == 3'h0)
    else $error("capability fixed bits wrong");

  a_aux_zero: assert property (s_cap_read |=> // R2
    cfg_rdata[20] == 1'b0)
    else $error("aux power bit not zero");

  a_clock_dep: assert property (s_cap_read |=> // R3
    cfg_rdata[19] == CAP_CLK_VAL)
    else $error("clock dependence bit changed");

  a_version_sel: assert property (s_cap_read |=> // R4
    cfg_rdata[18:16] == (($past(revision_select)) ? 3'h3 : 3'h2))
    else $error("version does not follow select");

  a_d3_reset_pulse: assert property (s_leave_d3hot |=> // R6
    func_reset ##1 !func_reset)
    else $error("internal reset pulse wrong");

  a_reset_keeps_csr: assert property ( // R5
    func_reset && !wr_csr_dw && !bus_reset_in |->
    (power_state == PWR_D0) ##1 ($stable(wake_enable) && power_state == PWR_D0))
    else $error("control register disturbed");

  a_status_sets: assert property (wake_event |=> // R7
    csr_word[15])
    else $error("wake status not set");

  a_clear_by_one: assert property ( // R8
    wr_csr_dw && cfg_be[1] && cfg_wdata[15] && !wake_event |=>
    !csr_word[15] && !wake_out)
    else $error("write one did not clear wake");

  a_zero_no_effect: assert property ( // R8
    wr_csr_dw && cfg_be[1] && !cfg_wdata[15] && csr_word[15] &&
    !(bus_reset_in && !wake_enable) |=> csr_word[15])
    else $error("write zero changed status");

  a_dyn_zero: assert property (s_csr_read |=> // R9
    cfg_rdata[14:9] == 6'h00)
    else $error("dynamic data fields not zero");

  a_enable_gates: assert property (!wake_enable |-> !wake_out) // R10
    else $error("wake asserted while disabled");

  a_enable_bus_rst: assert property ( // R11
    bus_reset_in && !(wr_csr_dw && cfg_be[1]) |=> $stable(wake_enable))
    else $error("bus reset touched wake enable");

  a_reserved_zero: assert property (s_csr_read |=> // R12
    cfg_rdata[7:2] == 6'h00 && cfg_rdata[21:16] == 6'h00)
    else $error("reserved bits not zero");

  a_state_write: assert property ( // R13
    wr_csr_dw && cfg_be[0] && !bus_reset_in |=>
    power_state == $past(cfg_wdata[1:0]))
    else $error("power state not written");

  a_context_keep: assert property ( // R14
    bus_reset_in && wake_enable && csr_word[15] &&
    !(wr_csr_dw && cfg_be[1] && cfg_wdata[CSR_STATUS_BIT]) |=> csr_word[15])
    else $error("wake context lost on bus reset");

  a_context_clear: assert property ( // R14
    bus_reset_in && !wake_enable && !wake_event |=> !csr_word[15])
    else $error("wake status kept on bus reset");

  a_bridge_bits: assert property (s_csr_read |=> // R15 R17
    cfg_rdata[23:16] == 8'hc0)
    else $error("bridge extension value wrong");

  a_sec_clock: assert property ( // R16 R17
    power_state == PWR_D3HOT ##1 power_state == PWR_D3HOT |->
    sec_clk_stop && !sec_power_off)
    else $error("secondary clock not stopped");

  a_sec_idle: assert property ( // R16
    power_state != PWR_D3HOT |=> !sec_power_off)
    else $error("secondary power removed outside D3hot");

  a_d3cold_wr: assert property ( // R18
    wr_cap_dw && cfg_be[3] |=> d3cold_wake_ff == $past(cfg_wdata[31]))
    else $error("D3cold wake bit not written");

  a_ro_ignored: assert property ( // R19
    wr_cap_dw && !cfg_be[3] |=> $stable(d3cold_wake_ff))
    else $error("read-only write changed capability");

  a_wake_follows: assert property ( // R10
    wake_out == (csr_word[15] && wake_enable))
    else $error("wake output does not follow status and enable");

  a_reset_once: assert property (func_reset |=> // R6
    !func_reset)
    else $error("internal reset longer than one cycle");

  a_reset_cause: assert property (func_reset |-> // R6
    $past(power_state) == PWR_D3HOT)
    else $error("internal reset without leaving D3hot");

  a_bus_rst_quiet: assert property (bus_reset_in |=> // R6
    power_state == PWR_D0 && !func_reset)
    else $error("bus reset left state or pulsed reset");

  a_state_hold: assert property ( // R19
    !(wr_csr_dw && cfg_be[0]) && !bus_reset_in |=> $stable(power_state))
    else $error("power state changed without a write");

  a_d3cold_kept: assert property ( // R18
    bus_reset_in && !(wr_cap_dw && cfg_be[3]) |=> $stable(d3cold_wake_ff))
    else $error("bus reset touched D3cold wake bit");

  a_status_read: assert property (s_csr_read |=> // R7
    cfg_rdata[15] == $past(csr_word[15]))
    else $error("read status differs from register");

  a_data_zero: assert property (s_csr_read |=>
    cfg_rdata[31:24] == PM_DATA_VAL)
    else $error("data register not zero");

  a_cap_header: assert property (s_cap_read |=>
    cfg_rdata[15:0] == {NEXT_PTR_VAL, CAP_ID_VAL})
    else $error("capability header wrong");

  a_unmapped_zero: assert property ( // R19
    rd_req && cfg_addr[7:2] != OFS_CAP_ID[7:2] && cfg_addr[7:2] != OFS_CSR[7:2] |=>
    cfg_rdata == 32'h0000_0000)
    else $error("unmapped dword not zero");

  a_rdata_hold: assert property (!rd_req |=> $stable(cfg_rdata))
    else $error("read data changed without a read");

  a_ack_only_req: assert property (!cfg_req |=> !cfg_ack)
    else $error("acknowledge without request");

  a_ack_timing: assert property (cfg_req |=> cfg_ack)
    else $error("request not answered");
endmodule

// file: verification/tb.sv
// Self-checking bench of the power management register bank.
// Assumes the one-cycle request/acknowledge config port of ppmr_top.
`timescale 1ns/10ps
module tb;
  import ppmr_pkg::*;

  logic        sys_clk;
  logic        srst;
  logic        bus_reset_in;
  logic        cfg_req;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;
  logic        revision_select;
  logic        wake_event;
  logic        wake_out;
  logic        func_reset;
  logic [1:0]  power_state;
  logic        sec_clk_stop;
  logic        sec_power_off;
  int          errors;
  int          n_compared;
  int          cycles;
  int          fr_cnt;

  ppmr_top u_ppmr_top (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .bus_reset_in    (bus_reset_in),
    .cfg_req         (cfg_req),
    .cfg_we          (cfg_we),
    .cfg_addr        (cfg_addr),
    .cfg_be          (cfg_be),
    .cfg_wdata       (cfg_wdata),
    .cfg_rdata       (cfg_rdata),
    .cfg_ack         (cfg_ack),
    .revision_select (revision_select),
    .wake_event      (wake_event),
    .wake_out        (wake_out),
    .func_reset      (func_reset),
    .power_state     (power_state),
    .sec_clk_stop    (sec_clk_stop),
    .sec_power_off   (sec_power_off)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 130 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (func_reset === 1'b1) begin
      fr_cnt++;
    end
    if (cycles == 3000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Request held for one edge; answer taken at the edge after
  task automatic cfg(input logic we, input logic [7:0] addr, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    cfg_req   <= 1'b1;
    cfg_we    <= we;
    cfg_addr  <= addr;
    cfg_be    <= be;
    cfg_wdata <= wd;
    @(posedge sys_clk);
    cfg_req <= 1'b0;
    #1;
    chk_bit(cfg_ack, 1'b1, "ack");
    rd = cfg_rdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] dummy;
    cfg(1'b1, addr, be, wd, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
    logic [31:0] r;
    cfg(1'b0, addr, 4'hf, 32'h0000_0000, r);
    chk_word(r, exp, what);
  endtask

  // One-cycle pulse on the bus reset or the wake event line
  task automatic hit(input bit bus);
    @(posedge sys_clk);
    if (bus) begin
      bus_reset_in <= 1'b1;
    end else begin
      wake_event <= 1'b1;
    end
    @(posedge sys_clk);
    bus_reset_in <= 1'b0;
    wake_event   <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    sys_clk         = 1'b0;
    srst            = 1'b1;
    bus_reset_in    = 1'b0;
    cfg_req         = 1'b0;
    cfg_we          = 1'b0;
    cfg_addr        = 8'h00;
    cfg_be          = 4'h0;
    cfg_wdata       = 32'h0000_0000;
    revision_select = 1'b0;
    wake_event      = 1'b0;
    errors          = 0;
    n_compared      = 0;
    cycles          = 0;
    fr_cnt          = 0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rd_chk(OFS_CAP_ID, 32'hfe02_0001, "caps");
    rd_chk(OFS_CSR, 32'h00c0_0000, "csr");
    rd_chk(8'ha6, 32'h00c0_0000, "csr alias");
    @(posedge sys_clk);
    revision_select <= 1'b1;
    rd_chk(OFS_CAP_ID, 32'hfe03_0001, "rev12");
    @(posedge sys_clk);
    revision_select <= 1'b0;
    // Firmware drops cold wake; aux bit must still read zero
    wr(OFS_CAP_ID, 4'h8, 32'h0000_0000);
    rd_chk(OFS_CAP_ID, 32'h7e02_0001, "cold off");
    wr(OFS_CAP_ID, 4'h7, 32'hffff_ffff);
    rd_chk(OFS_CAP_ID, 32'h7e02_0001, "caps ro");
    wr(OFS_CAP_ID, 4'h8, 32'h8000_0000);
    rd_chk(OFS_CAP_ID, 32'hfe02_0001, "cold on");
    rd_chk(8'ha8, 32'h0000_0000, "unmapped");
    wr(8'ha8, 4'hf, 32'hffff_ffff);
    rd_chk(OFS_CSR, 32'h00c0_0000, "after unmapped wr");
    fr_cnt = 0;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CSR, 4'h1, {30'h0, 2'(s)});
      chk_word({30'h0, power_state}, {30'h0, 2'(s)}, "state out");
      @(posedge sys_clk);
      #1;
      chk_bit(sec_clk_stop, s == 3, "clk stop");
      chk_bit(sec_power_off, 1'b0, "pwr off");
      rd_chk(OFS_CSR, {16'h00c0, 14'h0, 2'(s)}, "state rd");
    end
    chk_word(fr_cnt, 32'h0, "no func reset");
    wr(OFS_CSR, 4'hf, 32'hffff_ffff);
    rd_chk(OFS_CSR, 32'h00c0_0103, "all ones");
    fr_cnt = 0;
    wr(OFS_CSR, 4'h1, 32'h0000_0000);
    repeat (4) @(posedge sys_clk);
    #1;
    chk_word(fr_cnt, 32'h1, "func reset");
    chk_bit(sec_clk_stop, 1'b0, "clk restart");
    rd_chk(OFS_CSR, 32'h00c0_0100, "csr kept");
    // Leaving D3hot by bus reset must not pulse the internal reset
    wr(OFS_CSR, 4'h1, 32'h0000_0003);
    fr_cnt = 0;
    hit(1'b1);
    chk_word({30'h0, power_state}, 32'h0, "bus rst state");
    chk_word(fr_cnt, 32'h0, "no reset on bus rst");
    hit(1'b0);
    chk_bit(wake_out, 1'b1, "wake on");
    rd_chk(OFS_CSR, 32'h00c0_8100, "status set");
    wr(OFS_CSR, 4'h2, 32'h0000_0100);
    rd_chk(OFS_CSR, 32'h00c0_8100, "write zero");
    hit(1'b1);
    rd_chk(OFS_CSR, 32'h00c0_8100, "bus rst enabled");
    // Event and write-one clear sampled at the same edge
    fork
      wr(OFS_CSR, 4'h2, 32'h0000_8100);
      hit(1'b0);
    join
    rd_chk(OFS_CSR, 32'h00c0_8100, "set beats clear");
    wr(OFS_CSR, 4'h2, 32'h0000_8100);
    @(posedge sys_clk);
    #1;
    chk_bit(wake_out, 1'b0, "wake cleared");
    rd_chk(OFS_CSR, 32'h00c0_0100, "status cleared");
    wr(OFS_CSR, 4'h2, 32'h0000_0000);
    hit(1'b0);
    chk_bit(wake_out, 1'b0, "wake gated");
    rd_chk(OFS_CSR, 32'h00c0_8000, "status disabled");
    hit(1'b1);
    rd_chk(OFS_CSR, 32'h00c0_0000, "bus rst disabled");
    wr(OFS_CSR, 4'h3, 32'h0000_0102);
    wr(OFS_CAP_ID, 4'h8, 32'h0000_0000);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd_chk(OFS_CSR, 32'h00c0_0000, "global rst");
    rd_chk(OFS_CAP_ID, 32'hfe02_0001, "cold default");
    stop_test();
  end
endmodule
